/* bench/test_af_iir_set1_and_aewb_window_config.sv */
// Purpose: self-checking bench for the focus filter and stats window config bank
// Assumes: classic Wishbone master, ack after one cycle, decoded outputs one edge later
// Notes: mid-run reset is repeated to catch registers that miss the clear
module test_af_iir_set1_and_aewb_window_config
	import afw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic signed [11:0] filter_coef_eight, filter_coef_nine, filter_coef_ten;
	logic [8:0] window_height, window_width, black_row_height;
	logic [7:0] vertical_windows;
	logic [6:0] horizontal_windows;
	logic [11:0] first_window_line, first_window_column, black_row_line;
	logic width_too_narrow, hcount_out_of_range;
	int errors = 0;
	int cmp_count = 0;
	// writable bits of each word; everything else must read back as zero
	localparam logic [31:0] MASK [5] = '{32'h0fff0fff, 32'h00000fff, 32'h7f0fffff,
		32'h0fff0fff, 32'h0fff007f};

	afw_regs dut (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .filter_coef_eight(filter_coef_eight),
		.filter_coef_nine(filter_coef_nine), .filter_coef_ten(filter_coef_ten),
		.window_height(window_height), .window_width(window_width),
		.vertical_windows(vertical_windows), .horizontal_windows(horizontal_windows),
		.first_window_line(first_window_line), .first_window_column(first_window_column),
		.black_row_line(black_row_line), .black_row_height(black_row_height),
		.width_too_narrow(width_too_narrow), .hcount_out_of_range(hcount_out_of_range));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic end_sim();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// request held until ack is sampled; bounded wait guards a missing ack
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		input logic [3:0] sel, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: no ack", $time);
			end_sim();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] unused;
		xfer(1'b1, adr, dat, sel, unused);
	endtask : wr

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
		logic [31:0] got;
		xfer(1'b0, adr, 32'h0, 4'hf, got);
		chk(got, exp, what);
	endtask : rd_chk

	task automatic geom(input logic [6:0] h, input logic [6:0] w, input logic [6:0] v,
		input logic [5:0] hc);
		logic [31:0] word;
		word = {1'b0, h, 4'h0, w, v, hc};
		wr(OFF_GEOM, word, 4'hf);
		rd_chk(OFF_GEOM, word, "geometry");
		chk({23'h0, window_height}, ({25'h0, h} + 32'h1) << 1, "height");
		chk({23'h0, window_width}, ({25'h0, w} + 32'h1) << 1, "width");
		chk({24'h0, vertical_windows}, {25'h0, v} + 32'h1, "vertical");
		chk({25'h0, horizontal_windows}, {26'h0, hc} + 32'h1, "horizontal");
		rd_chk(OFF_STATUS, {30'h0, hc == 6'h0 || hc > 6'h23, w < 7'h2}, "status");
	endtask : geom

	initial begin
		rst_b = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 5; i++) rd_chk(8'(4 * i), 32'h0, "reset word");
		rd_chk(OFF_STATUS, 32'h3, "reset status");
		chk({23'h0, window_height}, 32'h2, "reset height");
		chk({23'h0, black_row_height}, 32'h2, "reset black height");
		chk({24'h0, vertical_windows}, 32'h1, "reset vertical");
		for (int i = 0; i < 5; i++) begin
			wr(8'(4 * i), 32'hffffffff, 4'hf);
			rd_chk(8'(4 * i), MASK[i], "ones word");
		end
		chk({20'h0, filter_coef_ten}, 32'hfff, "coef ten ones");
		chk({23'h0, window_height}, 32'h100, "max height");
		chk({24'h0, vertical_windows}, 32'h80, "max vertical");
		chk({23'h0, black_row_height}, 32'h100, "max black height");
		chk({30'h0, hcount_out_of_range, width_too_narrow}, 32'h2, "flags");
		wr(OFF_COEF_8_9, 32'h0, 4'b0001);
		rd_chk(OFF_COEF_8_9, 32'h0fff0f00, "lane 0");
		wr(OFF_COEF_8_9, 32'h0, 4'b0100);
		rd_chk(OFF_COEF_8_9, 32'h0f000f00, "lane 2");
		wr(OFF_COEF_8_9, 32'hf800f7ff, 4'hf);
		rd_chk(OFF_COEF_8_9, 32'h080007ff, "coef pair");
		chk({20'h0, filter_coef_eight}, 32'h7ff, "coef eight");
		chk({20'h0, filter_coef_nine}, 32'h800, "coef nine");
		wr(OFF_COEF_10, 32'hfffff800, 4'hf);
		rd_chk(OFF_COEF_10, 32'h800, "coef ten word");
		chk({20'h0, filter_coef_ten}, 32'h800, "coef ten");
		wr(OFF_START, 32'hf123f456, 4'hf);
		rd_chk(OFF_START, 32'h01230456, "start word");
		chk({20'h0, first_window_line}, 32'h123, "first line");
		chk({20'h0, first_window_column}, 32'h456, "first column");
		wr(OFF_START, 32'h00ab0c00, 4'h2);
		rd_chk(OFF_START, 32'h01230c56, "column lane");
		wr(OFF_START, 32'h00ab0000, 4'h4);
		rd_chk(OFF_START, 32'h01ab0c56, "line lane");
		geom(7'h00, 7'h01, 7'h00, 6'h00);
		geom(7'h7f, 7'h02, 7'h7f, 6'h01);
		geom(7'h05, 7'h7f, 7'h03, 6'h23);
		geom(7'h01, 7'h03, 7'h00, 6'h24);
		wr(OFF_BLACK, 32'hfabcff85, 4'hf);
		rd_chk(OFF_BLACK, 32'h0abc0005, "black word");
		chk({20'h0, black_row_line}, 32'habc, "black line");
		chk({23'h0, black_row_height}, 32'hc, "black height");
		chk({25'h0, horizontal_windows}, 32'h25, "shared count");
		wr(OFF_STATUS, 32'h0, 4'hf);
		rd_chk(OFF_STATUS, 32'h2, "status write ignored");
		rd_chk(8'h18, 32'h0, "unmapped");
		rd_chk(8'hfc, 32'h0, "unmapped top");
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		rd_chk(OFF_START, 32'h0, "second reset");
		chk({20'h0, filter_coef_nine}, 32'h0, "second reset coef");
		end_sim();
	end
endmodule : test_af_iir_set1_and_aewb_window_config

/* rtl/afw_decode.sv */
// Purpose: turns window codes into pixel sizes and window counts
// Assumes: codes come straight from the register bank
// Notes: pure combinational; the bank registers every result
module afw_decode
	import afw_pkg::*;
(
	afw_geom_if.dec g
);
	// sizes are (code + 1) * 2, i.e. code shifted left plus two
	assign g.height = {1'b0, g.height_code, 1'b0} + 9'h002;
	assign g.width = {1'b0, g.width_code, 1'b0} + 9'h002;
	assign g.blk_height = {1'b0, g.blk_height_code, 1'b0} + 9'h002;
	assign g.vcount = {1'b0, g.vcnt_code} + 8'h01;
	assign g.hcount = {1'b0, g.hcnt_code} + 7'h01;
	// flags only report; the bank still takes whatever software wrote
	assign g.narrow = g.width_code < WIDTH_CODE_MIN;
	assign g.hcnt_bad = (g.hcnt_code < HCNT_CODE_MIN) || (g.hcnt_code > HCNT_CODE_MAX);
endmodule : afw_decode

/* rtl/afw_geom_if.sv */
// Purpose: carries raw geometry codes to the decoder and decoded values back
// Assumes: purely combinational traffic on the register clock
// Notes: none
interface afw_geom_if;
	logic [6:0] height_code;
	logic [6:0] width_code;
	logic [6:0] vcnt_code;
	logic [5:0] hcnt_code;
	logic [6:0] blk_height_code;
	logic [8:0] height;
	logic [8:0] width;
	logic [8:0] blk_height;
	logic [7:0] vcount;
	logic [6:0] hcount;
	logic narrow;
	logic hcnt_bad;
	modport regs (output height_code, width_code, vcnt_code, hcnt_code, blk_height_code,
		input height, width, blk_height, vcount, hcount, narrow, hcnt_bad);
	modport dec (input height_code, width_code, vcnt_code, hcnt_code, blk_height_code,
		output height, width, blk_height, vcount, hcount, narrow, hcnt_bad);
endinterface : afw_geom_if

/* rtl/afw_pkg.sv */
// Purpose: constants and state type for the focus filter and stats window config bank
// Assumes: one clock, synchronous active-low reset, 32-bit classic Wishbone
// Notes: all programmable fields reset to zero
package afw_pkg;
	localparam logic [7:0] OFF_COEF_8_9 = 8'h00;
	localparam logic [7:0] OFF_COEF_10 = 8'h04;
	localparam logic [7:0] OFF_GEOM = 8'h08;
	localparam logic [7:0] OFF_START = 8'h0c;
	localparam logic [7:0] OFF_BLACK = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam int COEF_W = 12;
	localparam int CODE_W = 7;
	localparam int HCNT_W = 6;
	localparam int POS_W = 12;
	localparam int COEF_EIGHT_LSB = 0;
	localparam int COEF_NINE_LSB = 16;
	localparam int COEF_TEN_LSB = 0;
	localparam int HEIGHT_LSB = 24;
	localparam int WIDTH_LSB = 13;
	localparam int VCNT_LSB = 6;
	localparam int HCNT_LSB = 0;
	localparam int LINE_LSB = 16;
	localparam int COL_LSB = 0;
	localparam int BLK_LINE_LSB = 16;
	localparam int BLK_HEIGHT_LSB = 0;
	localparam int ST_NARROW_BIT = 0;
	localparam int ST_HCNT_BIT = 1;
	localparam logic [6:0] WIDTH_CODE_MIN = 7'h02;
	localparam logic [5:0] HCNT_CODE_MIN = 6'h01;
	localparam logic [5:0] HCNT_CODE_MAX = 6'h23;
	typedef struct packed {
		logic [11:0] filter_coef_eight;
		logic [11:0] filter_coef_nine;
		logic [11:0] filter_coef_ten;
		logic [6:0] window_height_code;
		logic [6:0] window_width_code;
		logic [6:0] vertical_window_count;
		logic [5:0] horizontal_window_count;
		logic [11:0] first_window_line;
		logic [11:0] first_window_column;
		logic [11:0] black_row_line;
		logic [6:0] black_row_height_code;
		logic ack;
		logic [31:0] rdata;
		logic [8:0] height;
		logic [8:0] width;
		logic [8:0] black_height;
		logic [7:0] vcount;
		logic [6:0] hcount;
		logic width_too_narrow;
		logic hcount_out_of_range;
	} afw_state_t;
	localparam afw_state_t AFW_STATE_RST = '0;
endpackage : afw_pkg

/* rtl/afw_regs.sv */
// Purpose: config bank for second focus filter set and exposure/balance window grid
// Assumes: classic Wishbone slave, single sys_clk, synchronous active-low rst_b
// Notes: ack one cycle after request, writes commit at the ack edge
//
// What this block does
// - each second-set coefficient is a 12-bit read/write signed fixed-point field
// - coefficient eight in bits 11-0, nine in bits 27-16, rest reserved
// - coefficient ten alone in bits 11-0, bits 31-12 reserved read zero
// - window height code at bits 30-24, height is (code+1)*2, 2 to 256
// - width code at bits 19-13, width (code+1)*2, software keeps it at least 6
// - vertical count at bits 12-6 is windows minus one, at most 128
// - horizontal count at bits 5-0 is windows minus one, kept 1 to 35
// - 12-bit first line of windows at bits 27-16
// - 12-bit first window column at bits 11-0, every window line
// - black row has own start line at 27-16, shares column and horizontal count
// - black row height code at bits 6-0, height (code+1)*2, 2 to 256
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
module afw_regs
	import afw_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic signed [11:0] filter_coef_eight,
	output logic signed [11:0] filter_coef_nine,
	output logic signed [11:0] filter_coef_ten,
	output logic [8:0] window_height,
	output logic [8:0] window_width,
	output logic [7:0] vertical_windows,
	output logic [6:0] horizontal_windows,
	output logic [11:0] first_window_line,
	output logic [11:0] first_window_column,
	output logic [11:0] black_row_line,
	output logic [8:0] black_row_height,
	output logic width_too_narrow,
	output logic hcount_out_of_range
);
	afw_state_t s;
	afw_state_t next_s;
	logic hit;
	logic commit;
	logic [7:0] adr;
	logic [31:0] rd_word;
	logic [31:0] wr_word;

	afw_geom_if g ();

	afw_decode u_decode (
		.g(g)
	);

	// the read image of each register; reserved bits stay zero by construction
	function automatic logic [31:0] afw_read(input afw_state_t st, input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (a == OFF_COEF_8_9) begin
			w[COEF_EIGHT_LSB +: COEF_W] = st.filter_coef_eight;
			w[COEF_NINE_LSB +: COEF_W] = st.filter_coef_nine;
		end else if (a == OFF_COEF_10) begin
			w[COEF_TEN_LSB +: COEF_W] = st.filter_coef_ten;
		end else if (a == OFF_GEOM) begin
			w[HEIGHT_LSB +: CODE_W] = st.window_height_code;
			w[WIDTH_LSB +: CODE_W] = st.window_width_code;
			w[VCNT_LSB +: CODE_W] = st.vertical_window_count;
			w[HCNT_LSB +: HCNT_W] = st.horizontal_window_count;
		end else if (a == OFF_START) begin
			w[LINE_LSB +: POS_W] = st.first_window_line;
			w[COL_LSB +: POS_W] = st.first_window_column;
		end else if (a == OFF_BLACK) begin
			w[BLK_LINE_LSB +: POS_W] = st.black_row_line;
			w[BLK_HEIGHT_LSB +: CODE_W] = st.black_row_height_code;
		end else if (a == OFF_STATUS) begin
			w[ST_NARROW_BIT] = st.width_too_narrow;
			w[ST_HCNT_BIT] = st.hcount_out_of_range;
		end
		return w;
	endfunction : afw_read

	// byte lanes not selected keep the current contents
	function automatic logic [31:0] afw_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return m;
	endfunction : afw_merge

	// low address bits ignored: every register is one aligned word
	assign adr = {wb_adr_i[7:2], 2'b00};
	assign hit = wb_cyc_i && wb_stb_i && !s.ack;
	// write lands at the edge where the master sees ack, while its data still stands
	assign commit = wb_cyc_i && wb_stb_i && wb_we_i && s.ack;
	assign rd_word = afw_read(s, adr);
	assign wr_word = afw_merge(rd_word, wb_dat_i, wb_sel_i);

	assign g.height_code = s.window_height_code;
	assign g.width_code = s.window_width_code;
	assign g.vcnt_code = s.vertical_window_count;
	assign g.hcnt_code = s.horizontal_window_count;
	assign g.blk_height_code = s.black_row_height_code;

	always_comb begin
		next_s = s;
		next_s.ack = hit;
		if (hit) begin
			next_s.rdata = rd_word;
		end
		// status and unmapped words take writes without effect
		if (commit) begin
			if (adr == OFF_COEF_8_9) begin
				next_s.filter_coef_eight = wr_word[COEF_EIGHT_LSB +: COEF_W];
				next_s.filter_coef_nine = wr_word[COEF_NINE_LSB +: COEF_W];
			end else if (adr == OFF_COEF_10) begin
				next_s.filter_coef_ten = wr_word[COEF_TEN_LSB +: COEF_W];
			end else if (adr == OFF_GEOM) begin
				next_s.window_height_code = wr_word[HEIGHT_LSB +: CODE_W];
				next_s.window_width_code = wr_word[WIDTH_LSB +: CODE_W];
				next_s.vertical_window_count = wr_word[VCNT_LSB +: CODE_W];
				next_s.horizontal_window_count = wr_word[HCNT_LSB +: HCNT_W];
			end else if (adr == OFF_START) begin
				next_s.first_window_line = wr_word[LINE_LSB +: POS_W];
				next_s.first_window_column = wr_word[COL_LSB +: POS_W];
			end else if (adr == OFF_BLACK) begin
				next_s.black_row_line = wr_word[BLK_LINE_LSB +: POS_W];
				next_s.black_row_height_code = wr_word[BLK_HEIGHT_LSB +: CODE_W];
			end
		end
		// decoded values lag their codes by one cycle so every output is a flop
		next_s.height = g.height;
		next_s.width = g.width;
		next_s.black_height = g.blk_height;
		next_s.vcount = g.vcount;
		next_s.hcount = g.hcount;
		next_s.width_too_narrow = g.narrow;
		next_s.hcount_out_of_range = g.hcnt_bad;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s <= AFW_STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	assign wb_ack_o = s.ack;
	assign wb_dat_o = s.rdata;
	assign filter_coef_eight = s.filter_coef_eight;
	assign filter_coef_nine = s.filter_coef_nine;
	assign filter_coef_ten = s.filter_coef_ten;
	assign window_height = s.height;
	assign window_width = s.width;
	assign vertical_windows = s.vcount;
	// black row reuses horizontal_windows and first_window_column
	assign horizontal_windows = s.hcount;
	assign first_window_line = s.first_window_line;
	assign first_window_column = s.first_window_column;
	assign black_row_line = s.black_row_line;
	assign black_row_height = s.black_height;
	assign width_too_narrow = s.width_too_narrow;
	assign hcount_out_of_range = s.hcount_out_of_range;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	logic full_wr;
	assign full_wr = commit && (wb_sel_i == 4'hf);

	ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack did not follow request by one cycle");
	coef_pair_write_a: assert property (full_wr && adr == OFF_COEF_8_9 |=>
		filter_coef_eight == $past(wb_dat_i[11:0]) && filter_coef_nine == $past(wb_dat_i[27:16]))
		else $error("coefficient pair not stored from its lanes");
	coef_pair_resv_a: assert property (wb_ack_o && $past(adr) == OFF_COEF_8_9 &&
		!$past(wb_we_i) |-> wb_dat_o[31:28] == 4'h0 && wb_dat_o[15:12] == 4'h0
		&& wb_dat_o[11:0] == filter_coef_eight)
		else $error("coefficient pair readback wrong");
	coef_ten_resv_a: assert property (wb_ack_o && $past(adr) == OFF_COEF_10 &&
		!$past(wb_we_i) |-> wb_dat_o[31:12] == 20'h00000 && wb_dat_o[11:0] == filter_coef_ten)
		else $error("coefficient ten readback wrong");
	height_decode_a: assert property (full_wr && adr == OFF_GEOM |->
		##2 window_height == {1'b0, $past(wb_dat_i[30:24], 2), 1'b0} + 9'h002)
		else $error("window height decode wrong");
	width_decode_a: assert property (full_wr && adr == OFF_GEOM |->
		##2 window_width == {1'b0, $past(wb_dat_i[19:13], 2), 1'b0} + 9'h002
		&& width_too_narrow == ($past(wb_dat_i[19:13], 2) < 7'h02))
		else $error("window width decode or narrow flag wrong");
	vcount_decode_a: assert property (full_wr && adr == OFF_GEOM |->
		##2 vertical_windows == {1'b0, $past(wb_dat_i[12:6], 2)} + 8'h01
		&& vertical_windows <= 8'h80)
		else $error("vertical window count decode wrong");
	hcount_decode_a: assert property (full_wr && adr == OFF_GEOM |->
		##2 horizontal_windows == {1'b0, $past(wb_dat_i[5:0], 2)} + 7'h01)
		else $error("horizontal window count decode wrong");
	start_write_a: assert property (full_wr && adr == OFF_START |=>
		first_window_line == $past(wb_dat_i[27:16])
		&& first_window_column == $past(wb_dat_i[11:0]))
		else $error("window start not stored");
	black_row_a: assert property (full_wr && adr == OFF_BLACK |=>
		black_row_line == $past(wb_dat_i[27:16]) ##1
		black_row_height == {1'b0, $past(wb_dat_i[6:0], 2), 1'b0} + 9'h002)
		else $error("black row line or height wrong");
	partial_lane_a: assert property (commit && wb_sel_i == 4'h1
		&& adr == OFF_START |=> first_window_column[11:8] == $past(first_window_column[11:8]))
		else $error("unselected byte lane was written");
	reset_zero_a: assert property (!$past(rst_b) |-> filter_coef_eight == 12'h000
		&& filter_coef_ten == 12'h000 && first_window_line == 12'h000 && !wb_ack_o)
		else $error("fields not zero after reset");


	// bus side: every answer belongs to a request, read data only moves on a take
	ack_needs_req_a: assert property (wb_ack_o |->
		$past(wb_cyc_i && wb_stb_i))
		else $error("ack without a preceding request");

	dat_hold_a: assert property (!(wb_cyc_i && wb_stb_i) |=>
		$stable(wb_dat_o))
		else $error("read data moved without a request");

	// readback images: fields in place, reserved bits zero
	coef_nine_read_a: assert property (wb_ack_o && $past(adr) == OFF_COEF_8_9 &&
		!$past(wb_we_i) |-> wb_dat_o[27:16] == filter_coef_nine)
		else $error("coefficient nine readback wrong");

	geom_resv_a: assert property (wb_ack_o && $past(adr) == OFF_GEOM &&
		!$past(wb_we_i) |-> wb_dat_o[31] == 1'b0 && wb_dat_o[23:20] == 4'h0)
		else $error("geometry reserved bits not zero");

	start_read_a: assert property (wb_ack_o && $past(adr) == OFF_START &&
		!$past(wb_we_i) |-> wb_dat_o[31:28] == 4'h0 && wb_dat_o[15:12] == 4'h0
		&& wb_dat_o[27:16] == first_window_line && wb_dat_o[11:0] == first_window_column)
		else $error("window start readback wrong");

	black_read_a: assert property (wb_ack_o && $past(adr) == OFF_BLACK &&
		!$past(wb_we_i) |-> wb_dat_o[31:28] == 4'h0 && wb_dat_o[15:7] == 9'h000
		&& wb_dat_o[27:16] == black_row_line)
		else $error("black row readback wrong");

	status_read_a: assert property (wb_ack_o && $past(adr) == OFF_STATUS &&
		!$past(wb_we_i) |-> wb_dat_o[31:2] == 30'h0 && wb_dat_o[0] == width_too_narrow
		&& wb_dat_o[1] == hcount_out_of_range)
		else $error("status readback wrong");

	unmapped_read_a: assert property (wb_ack_o && $past(adr) > OFF_STATUS &&
		!$past(wb_we_i) |-> wb_dat_o == 32'h0000_0000)
		else $error("unmapped word not zero");

	// writes: only the addressed word and its selected lanes move
	coef_ten_write_a: assert property (full_wr && adr == OFF_COEF_10 |=>
		filter_coef_ten == $past(wb_dat_i[11:0]))
		else $error("coefficient ten not stored");

	coef_hold_a: assert property (!commit |=>
		$stable(filter_coef_eight) && $stable(filter_coef_nine) && $stable(filter_coef_ten))
		else $error("coefficient changed without a write");

	start_hold_a: assert property (!commit |=>
		$stable(first_window_line) && $stable(first_window_column) && $stable(black_row_line))
		else $error("start position changed without a write");

	// decoded values trail a commit by two edges, their codes by one
	size_hold_a: assert property (!commit |-> ##2
		$stable(window_height) && $stable(window_width) && $stable(black_row_height))
		else $error("window size changed without a write");

	count_hold_a: assert property (!commit |-> ##2
		$stable(vertical_windows) && $stable(horizontal_windows)
		&& $stable(width_too_narrow) && $stable(hcount_out_of_range))
		else $error("window count changed without a write");

	hcnt_flag_a: assert property (full_wr && adr == OFF_GEOM |-> ##2
		hcount_out_of_range == ($past(wb_dat_i[5:0], 2) == 6'h00 || $past(wb_dat_i[5:0], 2) > 6'h23))
		else $error("horizontal count flag wrong");

	dead_write_a: assert property (commit && adr >= OFF_STATUS |=>
		$stable(filter_coef_ten) && $stable(first_window_line) && $stable(black_row_line))
		else $error("status or unmapped write changed a field");

	coef_lane_a: assert property (commit && !wb_sel_i[1] && adr == OFF_COEF_8_9 |=>
		$stable(filter_coef_eight[11:8]))
		else $error("coefficient eight upper lane written");

	coef_nine_lane_a: assert property (commit && !wb_sel_i[3] && adr == OFF_COEF_8_9 |=>
		$stable(filter_coef_nine[11:8]))
		else $error("coefficient nine upper lane written");

	coef_low_lane_a: assert property (commit && wb_sel_i == 4'h1 && adr == OFF_COEF_8_9 |=>
		filter_coef_eight[7:0] == $past(wb_dat_i[7:0]))
		else $error("coefficient eight low lane not stored");

	ten_lane_a: assert property (commit && !wb_sel_i[1] && adr == OFF_COEF_10 |=>
		$stable(filter_coef_ten[11:8]))
		else $error("coefficient ten upper lane written");

	line_lane_a: assert property (commit && wb_sel_i == 4'h4 && adr == OFF_START |=>
		first_window_line[7:0] == $past(wb_dat_i[23:16]) && $stable(first_window_line[11:8]))
		else $error("first line lane write wrong");

	col_lane_a: assert property (commit && wb_sel_i == 4'h2 && adr == OFF_START |=>
		first_window_column[11:8] == $past(wb_dat_i[11:8]) && $stable(first_window_column[7:0]))
		else $error("first column lane write wrong");

	black_lane_a: assert property (commit && !wb_sel_i[3] && adr == OFF_BLACK |=>
		$stable(black_row_line[11:8]))
		else $error("black line upper lane written");

	black_keep_a: assert property (commit && !wb_sel_i[0] && adr == OFF_BLACK |-> ##2
		$stable(black_row_height))
		else $error("black height changed without its lane");

	read_keep_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i |=>
		$stable(filter_coef_eight) && $stable(first_window_column) && $stable(black_row_line))
		else $error("read changed a field");

	// a second look at reset covering coefficient nine, first column, black row line and read data
	reset_more_a: assert property (!$past(rst_b) |-> filter_coef_nine == 12'h000
		&& first_window_column == 12'h000 && black_row_line == 12'h000
		&& wb_dat_o == 32'h0000_0000)
		else $error("remaining fields not zero after reset");

	// covers: the scenarios that matter most for the datapath
	read_coef_c: cover property (wb_ack_o && $past(adr) == OFF_COEF_8_9 && !$past(wb_we_i));
	write_geom_c: cover property (full_wr && adr == OFF_GEOM);
	narrow_flag_c: cover property ($rose(width_too_narrow));
	black_write_c: cover property (full_wr && adr == OFF_BLACK);
endmodule : afw_regs
